// *** logic/phpin_defs.vh ***
// Purpose: constants for the parallel host unit pin block
// Assumes: one clock, synchronous active-high reset
// Notes: port B bit positions of the shared pins
`ifndef PHPIN_DEFS_VH
`define PHPIN_DEFS_VH
`define PHPIN_PB_DATA_LO 5
`define PHPIN_PB_DATA_HI 7
`define PHPIN_PB_SEL_LO 8
`define PHPIN_PB_SEL_HI 10
`define PHPIN_PB_DIR 11
`define PHPIN_PB_STRB 12
`define PHPIN_PB_CS 13
`define PHPIN_PB_REQ 14
`define PHPIN_PB_ACK 15
`define PHPIN_PB_LO 5
`define PHPIN_PB_W 11
`define PHPIN_MODE_SINGLE 1'b0
`define PHPIN_MODE_DOUBLE 1'b1
`define PHPIN_REQ_SINGLE 1'b0
`define PHPIN_REQ_SPLIT 1'b1
`endif

// *** logic/phpin_od_pin.v ***
// Purpose: one open-drain pin driver for a request line
// Assumes: external pull-up holds the line high when released
// Notes: drives low only while asserted; in gpio mode follows i_gpio_out and i_gpio_oe
`timescale 1ns/1ps
`default_nettype none
module phpin_od_pin (
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // request and gpio fallback
  input wire i_req,
  input wire i_gpio_mode,
  input wire i_gpio_out,
  input wire i_gpio_oe,
  // pin
  output reg o_pin_out,
  output reg o_pin_oe
);
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end else if (i_gpio_mode) begin
      o_pin_out <= i_gpio_out;
      o_pin_oe <= i_gpio_oe;
    end else begin
      o_pin_out <= 1'b0;
      o_pin_oe <= i_req;
    end
  end
endmodule
`default_nettype wire

// *** logic/phpin_top.v ***
// Purpose: pin multiplexing of the parallel host unit port
// Assumes: host inputs synchronous to i_mclk
// Notes: pins fall back to port B bits 5..15 when host use is off
`timescale 1ns/1ps
`default_nettype none
`include "phpin_defs.vh"
module phpin_top (
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // configuration
  input wire i_host_enable,
  input wire i_double_strobe,
  input wire i_request_mode_bit,
  // shared pin inputs, port B bits 5..15
  input wire [`PHPIN_PB_W-1:0] i_pin_in,
  // gpio drive for port B bits 5..15
  input wire [`PHPIN_PB_W-1:0] i_gpio_out,
  input wire [`PHPIN_PB_W-1:0] i_gpio_oe,
  // service requests from the host unit
  input wire i_host_service_request,
  input wire i_transmit_service_request,
  input wire i_receive_service_request,
  // shared pin drive, port B bits 5..15
  output reg [`PHPIN_PB_W-1:0] o_pin_out,
  output reg [`PHPIN_PB_W-1:0] o_pin_oe,
  // gpio readback of port B bits 5..15
  output reg [`PHPIN_PB_W-1:0] o_gpio_in,
  // host side decoded access
  output reg [2:0] o_host_data_line_hi,
  output reg [2:0] o_host_register_select,
  output reg o_host_read,
  output reg o_host_write,
  output reg o_host_acknowledge_input
);
  localparam SEL_LO = `PHPIN_PB_SEL_LO - `PHPIN_PB_LO;
  localparam DIR_I = `PHPIN_PB_DIR - `PHPIN_PB_LO;
  localparam STRB_I = `PHPIN_PB_STRB - `PHPIN_PB_LO;
  localparam CS_I = `PHPIN_PB_CS - `PHPIN_PB_LO;
  localparam REQ_I = `PHPIN_PB_REQ - `PHPIN_PB_LO;
  localparam ACK_I = `PHPIN_PB_ACK - `PHPIN_PB_LO;

  // ----------------------------------------
  // input gating
  // ----------------------------------------
  wire live;
  wire cs_n;
  wire strb_n;
  wire dir;
  reg rd_d;
  reg wr_d;
  assign live = i_host_enable & ~i_rst;
  assign cs_n = i_pin_in[CS_I];
  assign strb_n = i_pin_in[STRB_I];
  assign dir = i_pin_in[DIR_I];

  always @* begin
    rd_d = 1'b0;
    wr_d = 1'b0;
    if (live && !cs_n) begin
      if (i_double_strobe == `PHPIN_MODE_SINGLE) begin
        rd_d = !strb_n && dir;
        wr_d = !strb_n && !dir;
      end else begin
        rd_d = !dir;
        wr_d = !strb_n;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_host_data_line_hi <= 3'h0;
      o_host_register_select <= 3'h0;
      o_host_read <= 1'b0;
      o_host_write <= 1'b0;
      o_host_acknowledge_input <= 1'b0;
      o_gpio_in <= {`PHPIN_PB_W{1'b0}};
    end else begin
      if (live) begin
        o_host_data_line_hi <= i_pin_in[2:0];
        o_host_register_select <= i_pin_in[SEL_LO+2:SEL_LO];
        o_host_acknowledge_input <= (i_request_mode_bit ==
          `PHPIN_REQ_SINGLE) & ~i_pin_in[ACK_I];
      end else begin
        o_host_data_line_hi <= 3'h0;
        o_host_register_select <= 3'h0;
        o_host_acknowledge_input <= 1'b0;
      end
      o_host_read <= rd_d;
      o_host_write <= wr_d;
      o_gpio_in <= i_host_enable ? {`PHPIN_PB_W{1'b0}} : i_pin_in;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  wire req_pin;
  wire ack_pin;
  wire [1:0] od_out;
  wire [1:0] od_oe;
  assign req_pin = (i_request_mode_bit == `PHPIN_REQ_SINGLE) ?
    i_host_service_request : i_transmit_service_request;
  assign ack_pin = (i_request_mode_bit == `PHPIN_REQ_SPLIT) &
    i_receive_service_request;

  phpin_od_pin u_req (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_req(req_pin),
    .i_gpio_mode(~i_host_enable),
    .i_gpio_out(i_gpio_out[REQ_I]),
    .i_gpio_oe(i_gpio_oe[REQ_I]),
    .o_pin_out(od_out[0]),
    .o_pin_oe(od_oe[0])
  );

  phpin_od_pin u_ack (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_req(ack_pin),
    .i_gpio_mode(~i_host_enable),
    .i_gpio_out(i_gpio_out[ACK_I]),
    .i_gpio_oe(i_gpio_oe[ACK_I]),
    .o_pin_out(od_out[1]),
    .o_pin_oe(od_oe[1])
  );

  reg [`PHPIN_PB_W-1:0] drv_out_q;
  reg [`PHPIN_PB_W-1:0] drv_oe_q;
  always @(posedge i_mclk) begin
    if (i_rst) begin
      drv_out_q <= {`PHPIN_PB_W{1'b0}};
      drv_oe_q <= {`PHPIN_PB_W{1'b0}};
    end else if (i_host_enable) begin
      drv_out_q <= {`PHPIN_PB_W{1'b0}};
      drv_oe_q <= {`PHPIN_PB_W{1'b0}};
    end else begin
      drv_out_q <= i_gpio_out;
      drv_oe_q <= i_gpio_oe;
    end
  end

  always @* begin
    o_pin_out = drv_out_q;
    o_pin_oe = drv_oe_q;
    o_pin_out[REQ_I] = od_out[0];
    o_pin_oe[REQ_I] = od_oe[0];
    o_pin_out[ACK_I] = od_out[1];
    o_pin_oe[ACK_I] = od_oe[1];
  end
endmodule
`default_nettype wire

// *** verification/phpin_host_model.sv ***
// Purpose: host side pins. Assumes: pull-up on request lines. Notes: none
`timescale 1ns/1ps
`default_nettype none
module phpin_host_model (
  // host drive and device drive
  input wire logic [10:0] i_drive,
  input wire logic [10:0] i_pin_out,
  input wire logic [10:0] i_pin_oe,
  // resolved pin levels
  output logic [10:0] o_pin
);
  // released lines show host level or pull-up
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_drive);
endmodule
`default_nettype wire

// *** verification/phpin_top_sva.sv ***
// Purpose: pin mux checks. Assumes: 1 cycle latency. Notes: none
`timescale 1ns/1ps
`default_nettype none
module phpin_top_sva (
  // clock, reset, config
  input wire logic i_mclk, i_rst, i_host_enable, i_double_strobe,
  input wire logic i_request_mode_bit, i_host_service_request,
  input wire logic i_transmit_service_request, i_receive_service_request,
  // pins and outputs
  input wire logic [10:0] i_pin_in, i_gpio_out, o_pin_out, o_pin_oe,
  input wire logic [10:0] o_gpio_in,
  input wire logic [2:0] o_host_data_line_hi, o_host_register_select,
  input wire logic o_host_read, o_host_write
);
  logic on_q, gp_q;
  logic [10:0] p_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_mclk) begin
    on_q <= !i_rst && i_host_enable;
    gp_q <= !i_rst && !i_host_enable;
    p_q <= i_pin_in;
  end
  AST_RST: assert property ($past(i_rst) |-> !o_host_read && !o_host_write
    && o_host_data_line_hi == 0 && o_pin_oe == 0) else $error("reset out");
  AST_DATA: assert property (on_q |-> o_host_data_line_hi == p_q[2:0]
    && o_host_register_select == p_q[5:3]) else $error("data sel");
  AST_RD1: assert property (on_q && !$past(i_double_strobe)
    |-> o_host_read == (!p_q[8] && !p_q[7] && p_q[6])) else $error("rd1");
  AST_WR1: assert property (on_q && !$past(i_double_strobe)
    |-> o_host_write == (!p_q[8] && !p_q[7] && !p_q[6])) else $error("wr1");
  AST_RD2: assert property (on_q && $past(i_double_strobe)
    |-> o_host_read == (!p_q[8] && !p_q[6])) else $error("rd2");
  AST_WR2: assert property (on_q && $past(i_double_strobe)
    |-> o_host_write == (!p_q[8] && !p_q[7])) else $error("wr2");
  AST_GPIO: assert property (gp_q |-> o_gpio_in == p_q
    && o_pin_out == $past(i_gpio_out)) else $error("gpio");
  AST_REQ0: assert property (on_q && !$past(i_request_mode_bit)
    |-> o_pin_oe[9] == $past(i_host_service_request) && !o_pin_out[9])
    else $error("req0");
  AST_REQ1: assert property (on_q && $past(i_request_mode_bit)
    |-> o_pin_oe[10:9] == {$past(i_receive_service_request),
    $past(i_transmit_service_request)} && o_pin_out[10:9] == 0)
    else $error("req1");
endmodule
bind phpin_top phpin_top_sva phpin_top_sva_inst (.*);
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: pin mux bench. Assumes: 100 MHz. Notes: levels, 1 cycle lag
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_mclk = 0, i_rst, i_host_enable, i_double_strobe;
  logic i_request_mode_bit, i_host_service_request;
  logic i_transmit_service_request, i_receive_service_request;
  logic [10:0] i_pin_in, i_gpio_out, i_gpio_oe, drv, o_pin_out, o_pin_oe;
  logic [10:0] o_gpio_in;
  logic [2:0] o_host_data_line_hi, o_host_register_select;
  logic o_host_read, o_host_write, o_host_acknowledge_input;
  int error_cnt = 0, check_count = 0;
  always #5 i_mclk = ~i_mclk;
  phpin_top phpin_top_inst (.*);
  phpin_host_model phpin_host_model_inst (.i_drive(drv),
    .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .o_pin(i_pin_in));
  task automatic chk(input string n, input logic [10:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic go(input logic [5:0] c, input logic [10:0] d);
    @(posedge i_mclk);
    {i_host_enable, i_double_strobe, i_request_mode_bit} <= c[5:3];
    {i_host_service_request, i_transmit_service_request} <= c[2:1];
    i_receive_service_request <= c[0];
    drv <= d;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {i_rst, drv, i_gpio_out, i_gpio_oe} = {1'b1, 11'h7FF, 22'h0};
    {i_host_enable, i_double_strobe, i_request_mode_bit} = 3'h0;
    {i_host_service_request, i_transmit_service_request} = 2'h0;
    i_receive_service_request = 0;
    i_host_enable = 1;
    repeat (6) @(posedge i_mclk);
    #1;
    chk("rst", 0, {o_host_data_line_hi, o_host_register_select});
    @(posedge i_mclk) i_rst <= 0;
    go(6'h20, 11'h66B);
    chk("sel", 11'h1D, {o_host_data_line_hi, o_host_register_select});
    chk("rw", 2, {o_host_read, o_host_write});
    go(6'h20, 11'h62B);
    chk("rw", 1, {o_host_read, o_host_write});
    go(6'h20, 11'h72B);
    chk("rw", 0, {o_host_read, o_host_write});
    go(6'h30, 11'h6AB);
    chk("rw", 2, {o_host_read, o_host_write});
    go(6'h30, 11'h66B);
    chk("rw", 1, {o_host_read, o_host_write});
    go(6'h24, 11'h26B);
    chk("req", 11'h004, {o_pin_oe[10:9], o_pin_out[9], i_pin_in[9]});
    chk("ack", 1, o_host_acknowledge_input);
    go(6'h2B, 11'h66B);
    chk("req", 11'h00C, {o_pin_oe[10:9], o_pin_out[10:9]});
    @(posedge i_mclk) i_gpio_out <= 11'h2AA;
    go(6'h00, 11'h555);
    chk("gin", 11'h555, o_gpio_in);
    chk("gout", 11'h2AA, o_pin_out);
    chk("goe", 11'h000, o_pin_oe);
    @(posedge i_mclk) i_gpio_oe <= 11'h00F;
    go(6'h00, 11'h555);
    chk("goe", 11'h00F, o_pin_oe);
    chk("gin", 11'h55A, o_gpio_in);
    stop_test;
  end
  initial begin
    #5000;
    error_cnt++;
    stop_test;
  end
endmodule
`default_nettype wire
